/* rtl/aur_pkg.sv */
// aur_pkg: register map, field layouts and types of the async serial port
package aur_pkg;
	// ***************************************************
	// register map
	// ***************************************************
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TXDATA = 8'h08;
	localparam logic [7:0] ADDR_RXDATA = 8'h0C;

	localparam int CTRL_W   = 13;
	localparam int STAT_W   = 6;
	localparam int DATA_W   = 8;
	localparam int SHIFT_W  = 9;

	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	// ***************************************************
	// timing
	// ***************************************************
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
	localparam logic [3:0] START_MID       = 4'h7;
	localparam logic [3:0] BITS_EIGHT      = 4'h8;
	localparam logic [3:0] BITS_NINE       = 4'h9;
	localparam logic [1:0] FIFO_DEPTH      = 2'h2;

	// ***************************************************
	// types
	// ***************************************************
	typedef struct packed {
		logic global_irq_enable;
		logic peripheral_irq_enable;
		logic transmit_irq_enable;
		logic receive_irq_enable;
		logic transmit_ninth_bit;
		logic transmit_polarity_select;
		logic address_detect_enable;
		logic nine_bit_transmit_enable;
		logic nine_bit_receive_enable;
		logic transmitter_enable;
		logic continuous_receive_enable;
		logic mode_sync;
		logic port_enable;
	} aur_ctrl_t;

	localparam aur_ctrl_t CTRL_RESET = '0;

	typedef struct packed {
		logic             framing_error;
		logic             ninth_bit;
		logic [DATA_W-1:0] data;
	} aur_entry_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} aur_rx_state_t;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_START = 2'b01,
		TX_DATA  = 2'b10,
		TX_STOP  = 2'b11
	} aur_tx_state_t;
endpackage

/* rtl/aur_uart.sv */
// aur_uart: async serial transmitter and receiver with an APB register slave
// ***************************************************
// ***************************************************
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module aur_uart (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        baud_tick_16x,
	input  wire logic        rx_in,
	output logic             tx_out,
	output logic             tx_oe,
	output logic             rx_irq_req,
	output logic             tx_irq_req
);
	// ***************************************************
	// registers and bus decode
	// ***************************************************
	aur_pkg::aur_ctrl_t            ctrl;
	aur_pkg::aur_entry_t           fifo [2];
	logic                          rd_ptr;
	logic                          wr_ptr;
	logic [1:0]                    fifo_count;
	logic                          overrun_error_flag;
	logic [aur_pkg::SHIFT_W-1:0]   transmit_buffer;
	logic                          buffer_full;
	logic [aur_pkg::SHIFT_W-1:0]   transmit_shifter;
	aur_pkg::aur_tx_state_t        tx_state;
	logic [3:0]                    tx_tick_cnt;
	logic [3:0]                    tx_bit_cnt;
	logic                          tx_line;
	aur_pkg::aur_rx_state_t        rx_state;
	logic [3:0]                    rx_tick_cnt;
	logic [3:0]                    rx_bit_cnt;
	logic [aur_pkg::SHIFT_W-1:0]   receive_shifter;
	logic [2:0]                    votes;
	logic                          rx_prev;

	logic access;
	logic setup;
	logic mapped;
	logic wr_txdata;
	logic rd_rxdata;
	logic rx_on;
	logic tx_on;
	logic receive_data_flag;
	logic transmit_buffer_empty_flag;
	logic framing_error_flag;
	logic vote;
	logic rx_mid;
	logic push;
	logic pop;
	logic stop_done;
	logic [3:0] rx_bits;
	aur_pkg::aur_entry_t head;
	aur_pkg::aur_entry_t new_entry;

	assign setup  = psel & ~penable;
	assign access = psel & penable;
	assign mapped = (paddr == aur_pkg::ADDR_CTRL) || (paddr == aur_pkg::ADDR_STATUS) ||
		(paddr == aur_pkg::ADDR_TXDATA) || (paddr == aur_pkg::ADDR_RXDATA);
	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;
	assign wr_txdata = access & pwrite & (paddr == aur_pkg::ADDR_TXDATA);
	assign rd_rxdata = access & ~pwrite & (paddr == aur_pkg::ADDR_RXDATA);

	assign rx_on = ctrl.continuous_receive_enable & ~ctrl.mode_sync & ctrl.port_enable;
	assign tx_on = ctrl.transmitter_enable & ~ctrl.mode_sync & ctrl.port_enable;

	assign head = fifo[rd_ptr];
	// flag is pure state, so a status write cannot touch it
	assign receive_data_flag = rx_on & (fifo_count != 2'h0);
	assign framing_error_flag = (fifo_count != 2'h0) & head.framing_error;
	// only a waiting character behind a busy shifter, or tx_on low, clears it
	assign transmit_buffer_empty_flag = tx_on &
		~(buffer_full & (tx_state != aur_pkg::TX_IDLE));

	assign rx_irq_req = receive_data_flag & ctrl.receive_irq_enable &
		ctrl.peripheral_irq_enable & ctrl.global_irq_enable;
	assign tx_irq_req = transmit_buffer_empty_flag & ctrl.transmit_irq_enable &
		ctrl.peripheral_irq_enable & ctrl.global_irq_enable;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= aur_pkg::CTRL_RESET;
		end else if (access & pwrite & (paddr == aur_pkg::ADDR_CTRL)) begin
			ctrl <= aur_pkg::aur_ctrl_t'(pwdata[aur_pkg::CTRL_W-1:0]);
		end
	end

	// read data is registered in the setup cycle, zero-wait access
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= aur_pkg::ZERO_WORD;
		end else if (setup & ~pwrite) begin
			unique case (paddr)
				aur_pkg::ADDR_CTRL: begin
					prdata <= {{(32-aur_pkg::CTRL_W){1'b0}}, ctrl};
				end
				aur_pkg::ADDR_STATUS: begin
					prdata <= {{(32-aur_pkg::STAT_W){1'b0}}, (tx_state == aur_pkg::TX_IDLE),
						head.ninth_bit & (fifo_count != 2'h0), overrun_error_flag,
						framing_error_flag, transmit_buffer_empty_flag,
						receive_data_flag};
				end
				aur_pkg::ADDR_RXDATA: begin
					prdata <= {{(32-aur_pkg::DATA_W){1'b0}}, head.data};
				end
				default: begin
					prdata <= aur_pkg::ZERO_WORD;
				end
			endcase
		end
	end

	// ***************************************************
	// receiver
	// ***************************************************
	// baud tick comes from an outside divider at 16x the bit rate
	assign rx_mid = baud_tick_16x & (rx_tick_cnt == aur_pkg::OVERSAMPLE_LAST);
	assign vote = (votes[0] & votes[1]) | (votes[1] & votes[2]) | (votes[0] & votes[2]);
	assign rx_bits = ctrl.nine_bit_receive_enable ? aur_pkg::BITS_NINE : aur_pkg::BITS_EIGHT;
	assign stop_done = (rx_state == aur_pkg::RX_STOP) & rx_mid;

	always_comb begin
		new_entry.framing_error = ~vote;
		new_entry.ninth_bit = ctrl.nine_bit_receive_enable & receive_shifter[8];
		new_entry.data = ctrl.nine_bit_receive_enable ? receive_shifter[7:0] :
			receive_shifter[8:1];
	end

	// with nine-bit receive on, address mode drops characters whose ninth bit is clear
	assign push = stop_done & ~overrun_error_flag & (fifo_count != aur_pkg::FIFO_DEPTH) &
		~(ctrl.address_detect_enable & ctrl.nine_bit_receive_enable &
		~new_entry.ninth_bit);
	assign pop = rd_rxdata & (fifo_count != 2'h0);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_prev <= 1'b1;
			votes <= 3'h7;
		end else begin
			rx_prev <= rx_in;
			if (baud_tick_16x) begin
				votes <= {votes[1:0], rx_in};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state <= aur_pkg::RX_IDLE;
			rx_tick_cnt <= 4'h0;
			rx_bit_cnt <= 4'h0;
			receive_shifter <= '0;
		end else if (!rx_on) begin
			rx_state <= aur_pkg::RX_IDLE;
		end else begin
			if (baud_tick_16x) begin
				rx_tick_cnt <= rx_tick_cnt + 4'h1;
			end
			unique case (rx_state)
				aur_pkg::RX_IDLE: begin
					// no new starts while overrun is pending
					if (rx_prev & ~rx_in & ~overrun_error_flag) begin
						rx_state <= aur_pkg::RX_START;
						rx_tick_cnt <= 4'h0;
					end
				end
				aur_pkg::RX_START: begin
					if (baud_tick_16x & (rx_tick_cnt == aur_pkg::START_MID)) begin
						if (rx_in) begin
							rx_state <= aur_pkg::RX_IDLE;
						end else begin
							rx_state <= aur_pkg::RX_DATA;
							rx_tick_cnt <= 4'h0;
							rx_bit_cnt <= 4'h0;
						end
					end
				end
				aur_pkg::RX_DATA: begin
					if (rx_mid) begin
						receive_shifter <= {vote, receive_shifter[8:1]};
						rx_bit_cnt <= rx_bit_cnt + 4'h1;
						if (rx_bit_cnt + 4'h1 == rx_bits) begin
							rx_state <= aur_pkg::RX_STOP;
						end
					end
				end
				aur_pkg::RX_STOP: begin
					if (rx_mid) begin
						rx_state <= aur_pkg::RX_IDLE;
					end
				end
			endcase
		end
	end

	// two entries; a third character may be shifting meanwhile
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			fifo_count <= 2'h0;
		end else if (!ctrl.port_enable) begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			fifo_count <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			if (push & ~pop) begin
				fifo_count <= fifo_count + 2'h1;
			end else if (pop & ~push) begin
				fifo_count <= fifo_count - 2'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			fifo[wr_ptr] <= new_entry;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			overrun_error_flag <= 1'b0;
		end else if (!ctrl.continuous_receive_enable | !ctrl.port_enable) begin
			overrun_error_flag <= 1'b0;
		end else if (stop_done & (fifo_count == aur_pkg::FIFO_DEPTH)) begin
			overrun_error_flag <= 1'b1;
		end
	end

	// ***************************************************
	// transmitter
	// ***************************************************
	// a write with tx_on high lands in the buffer; an idle shifter takes it next cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_buffer <= '0;
			buffer_full <= 1'b0;
		end else if (!tx_on) begin
			buffer_full <= 1'b0;
		end else if (wr_txdata) begin
			transmit_buffer <= {ctrl.transmit_ninth_bit,
				pwdata[aur_pkg::DATA_W-1:0]};
			buffer_full <= 1'b1;
		end else if (tx_state == aur_pkg::TX_IDLE) begin
			buffer_full <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state <= aur_pkg::TX_IDLE;
			tx_tick_cnt <= 4'h0;
			tx_bit_cnt <= 4'h0;
			transmit_shifter <= '0;
		end else if (!tx_on) begin
			tx_state <= aur_pkg::TX_IDLE;
		end else begin
			if (baud_tick_16x) begin
				tx_tick_cnt <= tx_tick_cnt + 4'h1;
			end
			unique case (tx_state)
				aur_pkg::TX_IDLE: begin
					if (buffer_full) begin
						transmit_shifter <= transmit_buffer;
						tx_tick_cnt <= 4'h0;
						tx_state <= aur_pkg::TX_START;
					end
				end
				aur_pkg::TX_START: begin
					if (baud_tick_16x & (tx_tick_cnt == aur_pkg::OVERSAMPLE_LAST)) begin
						tx_bit_cnt <= 4'h0;
						tx_state <= aur_pkg::TX_DATA;
					end
				end
				aur_pkg::TX_DATA: begin
					if (baud_tick_16x & (tx_tick_cnt == aur_pkg::OVERSAMPLE_LAST)) begin
						transmit_shifter <= {1'b0, transmit_shifter[8:1]};
						tx_bit_cnt <= tx_bit_cnt + 4'h1;
						if (tx_bit_cnt + 4'h1 == (ctrl.nine_bit_transmit_enable ?
							aur_pkg::BITS_NINE : aur_pkg::BITS_EIGHT)) begin
							tx_state <= aur_pkg::TX_STOP;
						end
					end
				end
				aur_pkg::TX_STOP: begin
					if (baud_tick_16x & (tx_tick_cnt == aur_pkg::OVERSAMPLE_LAST)) begin
						tx_state <= aur_pkg::TX_IDLE;
					end
				end
			endcase
		end
	end

	always_comb begin
		unique case (tx_state)
			aur_pkg::TX_START: tx_line = 1'b0;
			aur_pkg::TX_DATA:  tx_line = transmit_shifter[0];
			default:           tx_line = 1'b1;
		endcase
	end

	// output registered so the pin never glitches between states
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_out <= 1'b1;
			tx_oe <= 1'b0;
		end else begin
			tx_out <= tx_line ^ (ctrl.transmit_polarity_select & ~ctrl.mode_sync);
			tx_oe <= ctrl.port_enable;
		end
	end
endmodule

/* verification/aur_uart_asserts.sv */
// port-level checker for the async serial port
`timescale 1ns/1ns
module aur_uart_asserts (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        tx_out,
	input wire logic        rx_irq_req,
	input wire logic        tx_irq_req
);
	logic [12:0] c;
	logic [9:0]  idle;
	logic        cw;
	logic        tw;
	logic        go;
	assign cw = psel & penable & pwrite & (paddr == aur_pkg::ADDR_CTRL);
	assign tw = psel & penable & pwrite & (paddr == aur_pkg::ADDR_TXDATA);
	// buffer write to an idle, enabled, async, non-inverted transmitter
	assign go = tw & (idle >= 10'h2BC) & c[3] & c[0] & !c[1] & !c[7];
	// ***********************
	// shadow state
	// ***********************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			c <= '0;
		else if (cw)
			c <= pwdata[12:0];
	end
	// two eight-bit frames end well inside 700 cycles, so past that the line idles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			idle <= '0;
		else if (tw | (cw & (pwdata[7] != c[7])))
			idle <= '0;
		else if (idle != 10'h3FF)
			idle <= idle + 10'h001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	rx_irq_gate_a: assert property (rx_irq_req |-> c[9] & c[11] & c[12])
		else $error("receive request with an enable clear");
	tx_irq_gate_a: assert property (tx_irq_req |-> c[10] & c[11] & c[12])
		else $error("transmit request with an enable clear");
	tx_enable_flag_a: assert property (
		cw & !c[3] & (pwdata[12:10] == 3'h7) & ((pwdata[3:0] & 4'hB) == 4'h9) |=> tx_irq_req)
		else $error("no transmit request after enable");
	tx_idle_level_a: assert property (idle >= 10'h2BC |-> tx_out == !c[7])
		else $error("idle line level wrong");
	tx_start_a: assert property (go |-> ##[1:4] !tx_out)
		else $error("no start bit after buffer write");
	tx_flag_hold_a: assert property (go & (c[12:10] == 3'h7) |=> tx_irq_req [*3])
		else $error("transmit flag dropped on idle write");
	status_ro_a: assert property (
		psel & penable & pwrite & (paddr == aur_pkg::ADDR_STATUS) |=> $stable(rx_irq_req))
		else $error("status write moved the receive flag");
	port_off_a: assert property (cw & !pwdata[0] |=> !rx_irq_req [*2])
		else $error("receive flag kept after port disable");
	rx_rise_a: assert property ($rose(rx_irq_req) |-> c[0] & c[2] & !c[1])
		else $error("receive flag rose with receiver off");
endmodule

/* verification/aur_line_model.sv */
// remote serial transceiver: drives the receive line, decodes the transmit line
`timescale 1ns/1ns
module aur_line_model #(
	parameter int BIT = 32
) (
	input  wire logic       clk,
	input  wire logic       tx_out,
	output logic            rx_in,
	output logic [8:0]      got
);
	initial rx_in = 1'b1; // pulled-up idle mark
	task automatic send(input logic [8:0] d, input int n, input logic stp);
		rx_in <= 1'b0; // start bit
		repeat (BIT) @(posedge clk);
		for (int i = 0; i < n; i++) begin // lsb first
			rx_in <= d[i];
			repeat (BIT) @(posedge clk);
		end
		rx_in <= stp;
		repeat (BIT) @(posedge clk);
		rx_in <= 1'b1;
		repeat (BIT) @(posedge clk);
	endtask
	// shorter than half a bit, so it must be dropped
	task automatic glitch();
		rx_in <= 1'b0;
		repeat (BIT / 4) @(posedge clk);
		rx_in <= 1'b1;
		repeat (BIT) @(posedge clk);
	endtask
	// nine mid-bit samples: ninth bit or the stop bit lands in got[8]
	always begin
		@(negedge tx_out);
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge clk);
			got[i] = tx_out;
		end
	end
endmodule

/* verification/testbench.sv */
// self-checking bench for the async serial port
`timescale 1ns/1ns
module testbench;
	typedef struct packed {
		logic [8:0] d;
		logic       nine;
		logic       stp;
		logic [5:0] st;
	} aur_row_t;
	localparam logic [31:0] BASE = 32'h0000_1E0D;
	localparam int          BIT  = 32;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, tick;
	logic        rx_in, tx_out, tx_oe, rx_irq_req, tx_irq_req, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [8:0]  got;
	aur_row_t    r;
	int          fails;
	int          comparisons;
	aur_row_t    rows [5] = '{'{9'h0A5, 1'b0, 1'b1, 6'h23}, '{9'h05A, 1'b0, 1'b0, 6'h27},
		'{9'h1C3, 1'b1, 1'b1, 6'h33}, '{9'h03C, 1'b1, 1'b0, 6'h27}, '{9'h0FF, 1'b0, 1'b1, 6'h23}};
	aur_uart dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .baud_tick_16x(tick), .rx_in, .tx_out, .tx_oe, .rx_irq_req, .tx_irq_req);
	aur_line_model #(.BIT(BIT)) line_u (.clk, .tx_out, .rx_in, .got);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// tick every other clock: sixteen ticks, 32 clocks per bit
	always @(posedge clk) tick <= ~tick;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n == 20) begin
			fails++;
			print_verdict();
		end
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		print_verdict();
	end
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, tick} = '0;
		repeat (10) @(posedge clk);
		check(prdata, 32'h0000_0000);
		check(32'({tx_oe, tx_out}), 32'h0000_0001);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(1'b0, aur_pkg::ADDR_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0020);
		bus(1'b0, 8'h10, 32'h0000_0000);
		check(32'(err), 32'h0000_0001);
		$display("done: reset and unmapped");
		for (int i = 0; i < 5; i++) begin
			r = rows[i];
			bus(1'b1, aur_pkg::ADDR_CTRL, BASE | {23'h0, r.d[8], 2'h0, r.nine, r.nine, 4'h0});
			line_u.send(r.d, 8 + int'(r.nine), r.stp);
			bus(1'b0, aur_pkg::ADDR_STATUS, 32'h0000_0000);
			check(rd, {26'h0, r.st});
			check(32'(rx_irq_req), 32'h0000_0001);
			bus(1'b0, aur_pkg::ADDR_RXDATA, 32'h0000_0000);
			check(rd, {24'h0, r.d[7:0]});
			bus(1'b0, aur_pkg::ADDR_STATUS, 32'h0000_0000);
			check(rd & 32'h0000_0001, 32'h0000_0000);
			bus(1'b1, aur_pkg::ADDR_TXDATA, {24'h0, r.d[7:0]});
			repeat (11 * BIT) @(posedge clk);
			check(32'(got), r.nine ? 32'(r.d) : {24'h00_0001, r.d[7:0]});
			$display("done: row %0d", i);
		end
		line_u.glitch();
		bus(1'b1, aur_pkg::ADDR_STATUS, 32'h0000_003F);
		bus(1'b0, aur_pkg::ADDR_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0022);
		$display("done: glitch");
		bus(1'b1, aur_pkg::ADDR_CTRL, BASE);
		for (int k = 1; k < 4; k++)
			line_u.send(9'(17 * k), 8, 1'b1);
		bus(1'b0, aur_pkg::ADDR_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_002B);
		for (int k = 1; k < 3; k++) begin
			bus(1'b0, aur_pkg::ADDR_RXDATA, 32'h0000_0000);
			check(rd, 32'(17 * k));
		end
		line_u.send(9'h044, 8, 1'b1);
		bus(1'b0, aur_pkg::ADDR_STATUS, 32'h0000_0000);
		check(rd & 32'h0000_0009, 32'h0000_0008);
		bus(1'b1, aur_pkg::ADDR_CTRL, 32'h0000_1E09);
		bus(1'b0, aur_pkg::ADDR_STATUS, 32'h0000_0000);
		check(rd & 32'h0000_0009, 32'h0000_0000);
		$display("done: overrun");
		bus(1'b1, aur_pkg::ADDR_CTRL, BASE);
		line_u.send(9'h000, 8, 1'b0);
		bus(1'b1, aur_pkg::ADDR_CTRL, 32'h0000_1E09);
		bus(1'b0, aur_pkg::ADDR_STATUS, 32'h0000_0000);
		check(rd & 32'h0000_0004, 32'h0000_0004);
		bus(1'b1, aur_pkg::ADDR_CTRL, 32'h0000_1E0C);
		bus(1'b0, aur_pkg::ADDR_STATUS, 32'h0000_0000);
		check(rd & 32'h0000_0004, 32'h0000_0000);
		$display("done: framing");
		bus(1'b1, aur_pkg::ADDR_CTRL, 32'h0000_1E5D);
		line_u.send(9'h012, 9, 1'b1);
		bus(1'b0, aur_pkg::ADDR_STATUS, 32'h0000_0000);
		check(rd & 32'h0000_0001, 32'h0000_0000);
		line_u.send(9'h1AB, 9, 1'b1);
		bus(1'b0, aur_pkg::ADDR_STATUS, 32'h0000_0000);
		check(rd & 32'h0000_0011, 32'h0000_0011);
		bus(1'b0, aur_pkg::ADDR_RXDATA, 32'h0000_0000);
		check(rd, 32'h0000_00AB);
		bus(1'b1, aur_pkg::ADDR_CTRL, 32'h0000_1E1D);
		line_u.send(9'h034, 9, 1'b1);
		bus(1'b0, aur_pkg::ADDR_RXDATA, 32'h0000_0000);
		check(rd, 32'h0000_0034);
		$display("done: address");
		bus(1'b1, aur_pkg::ADDR_CTRL, BASE);
		bus(1'b1, aur_pkg::ADDR_TXDATA, 32'h0000_0096);
		bus(1'b1, aur_pkg::ADDR_TXDATA, 32'h0000_003C);
		bus(1'b0, aur_pkg::ADDR_STATUS, 32'h0000_0000);
		check(rd & 32'h0000_0002, 32'h0000_0000);
		check(32'(tx_irq_req), 32'h0000_0000);
		repeat (10 * BIT) @(posedge clk);
		check(32'(got), 32'h0000_0196);
		repeat (330) @(posedge clk);
		check(32'(got), 32'h0000_013C);
		check(32'(tx_irq_req), 32'h0000_0001);
		$display("done: back to back");
		bus(1'b1, aur_pkg::ADDR_CTRL, BASE | 32'h0000_0080);
		repeat (720) @(posedge clk);
		check(32'({tx_oe, tx_out}), 32'h0000_0002);
		$display("done: polarity");
		// sync mode stops both directions, so the transmit flag must drop
		bus(1'b1, aur_pkg::ADDR_CTRL, 32'h0000_1E0F);
		bus(1'b0, aur_pkg::ADDR_STATUS, 32'h0000_0000);
		check(rd & 32'h0000_0003, 32'h0000_0000);
		check(32'(tx_irq_req), 32'h0000_0000);
		$display("done: sync mode");
		print_verdict();
	end
endmodule
bind aur_uart aur_uart_asserts chk_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
	.tx_out, .rx_irq_req, .tx_irq_req);
